// ===== design/pcr_regs.v
/*
 * pcr_regs.v: write-only byte-wide control register bank for the buzzer
 * prescaler and period, the PWM periods and output modes, the port digital
 * input enables and the port B low-level wake-up enables.
 * assumes: a plain register port synchronous to clk_sys; the buzzer tone and
 * PWM datapaths sit outside; the buzzer prescaler and port input gating are in here.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pcr_defs.vh"

////////////////////////////////////////////////////////////////////////////
module pcr_regs (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // buzzer controls
    output reg  [1:0]  buzzer_prescale_select,
    output reg  [2:0]  buzzer_div_log2,
    output reg  [5:0]  buzzer_period_value,
    output reg         buzzer_clk_en,
    // pwm controls
    output reg  [7:0]  pwm_ch0_period,
    output reg  [7:0]  pwm_ch1_period,
    output reg  [1:0]  ch0_differential_mode,
    output reg  [1:0]  ch1_differential_mode,
    output reg  [1:0]  ch0_nonoverlap_select,
    output reg  [1:0]  ch1_nonoverlap_select,
    output reg  [2:0]  ch0_nonoverlap_clks,
    output reg  [2:0]  ch1_nonoverlap_clks,
    // port gating
    input  wire [7:0]  port_a_pin_in,
    input  wire [5:0]  port_b_pin_in,
    input  wire [7:0]  port_d_pin_in,
    output reg  [7:0]  port_a_input_enable,
    output reg  [5:0]  port_b_input_enable,
    output reg  [7:0]  port_d_input_enable,
    output reg  [7:0]  port_a_din,
    output reg  [5:0]  port_b_din,
    output reg  [7:0]  port_d_din,
    // wake-up
    output reg  [5:0]  port_b_wakeup_enable,
    output reg         wakeup_req,
    // misuse flag
    output reg         reserved_write_seen
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function [2:0] nov_clks;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    nov_clks = `PCR_NOV_CLK_0;
                2'h1:    nov_clks = `PCR_NOV_CLK_1;
                2'h2:    nov_clks = `PCR_NOV_CLK_2;
                default: nov_clks = `PCR_NOV_CLK_3;
            endcase
        end
    endfunction

    function [2:0] div_log2;
        input [1:0] sel;
        begin
            div_log2 = {1'b0, sel} + `PCR_BUZ_DIV_LOG2_BASE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write decode

    // one comparator per register; all share the same qualifier
    function wr_hit;
        input       wr;
        input [7:0] addr;
        input [7:0] offset;
        begin
            wr_hit = wr && (addr == offset);
        end
    endfunction

    wire       wr_buz  = wr_hit(reg_wr, reg_addr, `PCR_OFF_BUZ_CTL);
    wire       wr_p0   = wr_hit(reg_wr, reg_addr, `PCR_OFF_PWM0_PRD);
    wire       wr_p1   = wr_hit(reg_wr, reg_addr, `PCR_OFF_PWM1_PRD);
    wire       wr_pa   = wr_hit(reg_wr, reg_addr, `PCR_OFF_PA_IEN);
    wire       wr_pb   = wr_hit(reg_wr, reg_addr, `PCR_OFF_PB_IEN);
    wire       wr_pd   = wr_hit(reg_wr, reg_addr, `PCR_OFF_PD_IEN);
    wire       wr_wk   = wr_hit(reg_wr, reg_addr, `PCR_OFF_PB_WKEN);
    wire       wr_ctl  = wr_hit(reg_wr, reg_addr, `PCR_OFF_PWM_CTL);
    // the reserved slot holds nothing here; a write is only recorded
    wire       wr_rsv  = wr_hit(reg_wr, reg_addr, `PCR_OFF_RESERVED);

    ////////////////////////////////////////////////////////////////////////
    // next values: hold unless the matching offset is written

    reg  [1:0] nxt_buzzer_prescale_select;
    reg  [5:0] nxt_buzzer_period_value;
    reg  [7:0] nxt_pwm_ch0_period;
    reg  [7:0] nxt_pwm_ch1_period;
    reg  [7:0] nxt_port_a_input_enable;
    reg  [5:0] nxt_port_b_input_enable;
    reg  [7:0] nxt_port_d_input_enable;
    reg  [5:0] nxt_port_b_wakeup_enable;
    reg  [1:0] nxt_ch1_differential_mode;
    reg  [1:0] nxt_ch1_nonoverlap_select;
    reg  [1:0] nxt_ch0_differential_mode;
    reg  [1:0] nxt_ch0_nonoverlap_select;
    reg        nxt_reserved_write_seen;

    always @* begin
        nxt_buzzer_prescale_select = buzzer_prescale_select;
        nxt_buzzer_period_value    = buzzer_period_value;
        nxt_pwm_ch0_period         = pwm_ch0_period;
        nxt_pwm_ch1_period         = pwm_ch1_period;
        nxt_port_a_input_enable    = port_a_input_enable;
        nxt_port_b_input_enable    = port_b_input_enable;
        nxt_port_d_input_enable    = port_d_input_enable;
        nxt_port_b_wakeup_enable   = port_b_wakeup_enable;
        nxt_ch1_differential_mode  = ch1_differential_mode;
        nxt_ch1_nonoverlap_select  = ch1_nonoverlap_select;
        nxt_ch0_differential_mode  = ch0_differential_mode;
        nxt_ch0_nonoverlap_select  = ch0_nonoverlap_select;
        nxt_reserved_write_seen    = reserved_write_seen;
        if (wr_buz) begin
            nxt_buzzer_prescale_select =
                reg_wdata[`PCR_BUZ_PSC_HI:`PCR_BUZ_PSC_LO];
            nxt_buzzer_period_value =
                reg_wdata[`PCR_BUZ_PRD_HI:`PCR_BUZ_PRD_LO];
        end
        if (wr_p0) begin
            nxt_pwm_ch0_period = reg_wdata;
        end
        if (wr_p1) begin
            nxt_pwm_ch1_period = reg_wdata;
        end
        if (wr_pa) begin
            nxt_port_a_input_enable = reg_wdata;
        end
        // port B has six pins; the top two data bits are dropped
        if (wr_pb) begin
            nxt_port_b_input_enable = reg_wdata[5:0];
        end
        if (wr_pd) begin
            nxt_port_d_input_enable = reg_wdata;
        end
        if (wr_wk) begin
            nxt_port_b_wakeup_enable = reg_wdata[5:0];
        end
        if (wr_ctl) begin
            nxt_ch1_differential_mode =
                reg_wdata[`PCR_CH1_MODE_HI:`PCR_CH1_MODE_LO];
            nxt_ch1_nonoverlap_select =
                reg_wdata[`PCR_CH1_NOV_HI:`PCR_CH1_NOV_LO];
            nxt_ch0_differential_mode =
                reg_wdata[`PCR_CH0_MODE_HI:`PCR_CH0_MODE_LO];
            nxt_ch0_nonoverlap_select =
                reg_wdata[`PCR_CH0_NOV_HI:`PCR_CH0_NOV_LO];
        end
        // sticky so a misbehaving driver can be spotted later
        if (wr_rsv) begin
            nxt_reserved_write_seen = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buzzer control register

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            buzzer_prescale_select <= `PCR_RST_BUZ_PSC;
            buzzer_period_value    <= `PCR_RST_BUZ_PRD;
        end else begin
            buzzer_prescale_select <= nxt_buzzer_prescale_select;
            buzzer_period_value    <= nxt_buzzer_period_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm period registers

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pwm_ch0_period <= `PCR_RST_PWM_PRD;
            pwm_ch1_period <= `PCR_RST_PWM_PRD;
        end else begin
            pwm_ch0_period <= nxt_pwm_ch0_period;
            pwm_ch1_period <= nxt_pwm_ch1_period;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port input enable registers

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            port_a_input_enable <= `PCR_RST_PA_IEN;
            port_b_input_enable <= `PCR_RST_PB_IEN;
            port_d_input_enable <= `PCR_RST_PD_IEN;
        end else begin
            port_a_input_enable <= nxt_port_a_input_enable;
            port_b_input_enable <= nxt_port_b_input_enable;
            port_d_input_enable <= nxt_port_d_input_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port B wake-up enable register

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            port_b_wakeup_enable <= `PCR_RST_PB_WKEN;
        end else begin
            port_b_wakeup_enable <= nxt_port_b_wakeup_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm output control register

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ch1_differential_mode <= `PCR_RST_CH_MODE;
            ch1_nonoverlap_select <= `PCR_RST_CH_NOV;
            ch0_differential_mode <= `PCR_RST_CH_MODE;
            ch0_nonoverlap_select <= `PCR_RST_CH_NOV;
        end else begin
            ch1_differential_mode <= nxt_ch1_differential_mode;
            ch1_nonoverlap_select <= nxt_ch1_nonoverlap_select;
            ch0_differential_mode <= nxt_ch0_differential_mode;
            ch0_nonoverlap_select <= nxt_ch0_nonoverlap_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reserved slot misuse flag

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reserved_write_seen <= 1'b0;
        end else begin
            reserved_write_seen <= nxt_reserved_write_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded controls, registered so every output is a flip-flop

    reg  [2:0] nxt_buzzer_div_log2;
    reg  [2:0] nxt_ch0_nonoverlap_clks;
    reg  [2:0] nxt_ch1_nonoverlap_clks;

    always @* begin
        nxt_buzzer_div_log2 = div_log2(buzzer_prescale_select);
        nxt_ch0_nonoverlap_clks = nov_clks(ch0_nonoverlap_select);
        nxt_ch1_nonoverlap_clks = nov_clks(ch1_nonoverlap_select);
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            buzzer_div_log2     <= `PCR_RST_BUZ_DIV;
            ch0_nonoverlap_clks <= `PCR_NOV_CLK_0;
            ch1_nonoverlap_clks <= `PCR_NOV_CLK_0;
        end else begin
            buzzer_div_log2     <= nxt_buzzer_div_log2;
            ch0_nonoverlap_clks <= nxt_ch0_nonoverlap_clks;
            ch1_nonoverlap_clks <= nxt_ch1_nonoverlap_clks;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buzzer clock prescaler: one-cycle enable every 8/16/32/64 clocks

    reg  [5:0] psc_cnt_ff;
    wire [5:0] psc_last = (6'h01 << buzzer_div_log2) - 6'h01;
    wire [5:0] nxt_psc_cnt = (psc_cnt_ff >= psc_last) ? 6'h00
                                                      : psc_cnt_ff + 6'h01;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            psc_cnt_ff    <= 6'h00;
            buzzer_clk_en <= 1'b0;
        end else begin
            psc_cnt_ff    <= nxt_psc_cnt;
            buzzer_clk_en <= (psc_cnt_ff >= psc_last);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port input gating and wake-up

    reg  [7:0] nxt_port_a_din;
    reg  [5:0] nxt_port_b_din;
    reg  [7:0] nxt_port_d_din;
    reg        nxt_wakeup_req;

    always @* begin
        // a blocked pin reads as zero
        nxt_port_a_din = port_a_pin_in & port_a_input_enable;
        nxt_port_b_din = port_b_pin_in & port_b_input_enable;
        nxt_port_d_din = port_d_pin_in & port_d_input_enable;
        // wake works on the raw pin: gating the input must not mask it
        nxt_wakeup_req = |(~port_b_pin_in & port_b_wakeup_enable);
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            port_a_din <= 8'h00;
            port_b_din <= 6'h00;
            port_d_din <= 8'h00;
            wakeup_req <= 1'b0;
        end else begin
            port_a_din <= nxt_port_a_din;
            port_b_din <= nxt_port_b_din;
            port_d_din <= nxt_port_d_din;
            wakeup_req <= nxt_wakeup_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: registers are write-only, reads return zero

    always @(posedge clk_sys) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= 8'h00;
    end

endmodule

`default_nettype wire

// ===== design/pcr_defs.vh
/*
 * pcr_defs.vh: register offsets, field positions and reset values of the
 * peripheral control register bank.
 * assumes: included by the bank's design file only, by bare name.
 */
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// register offsets (byte-wide registers, plain address port)
`define PCR_ADDR_W            8
`define PCR_OFF_BUZ_CTL       8'h0e
`define PCR_OFF_RESERVED      8'h0f
`define PCR_OFF_PWM0_PRD      8'h10
`define PCR_OFF_PWM1_PRD      8'h11
`define PCR_OFF_PA_IEN        8'h12
`define PCR_OFF_PB_IEN        8'h13
`define PCR_OFF_PD_IEN        8'h14
`define PCR_OFF_PB_WKEN       8'h15
`define PCR_OFF_PWM_CTL       8'h16

// reset values
`define PCR_RST_BUZ_PSC       2'h0
`define PCR_RST_BUZ_PRD       6'h00
`define PCR_RST_PWM_PRD       8'hff
`define PCR_RST_PA_IEN        8'hff
`define PCR_RST_PB_IEN        6'h3f
`define PCR_RST_PD_IEN        8'hff
`define PCR_RST_PB_WKEN       6'h00
`define PCR_RST_PWM_CTL       8'h00
`define PCR_RST_CH_MODE       2'h0
`define PCR_RST_CH_NOV        2'h0
`define PCR_RST_BUZ_DIV       3'h3

// field positions
`define PCR_BUZ_PSC_HI        7
`define PCR_BUZ_PSC_LO        6
`define PCR_BUZ_PRD_HI        5
`define PCR_BUZ_PRD_LO        0
`define PCR_CH1_MODE_HI       7
`define PCR_CH1_MODE_LO       6
`define PCR_CH1_NOV_HI        5
`define PCR_CH1_NOV_LO        4
`define PCR_CH0_MODE_HI       3
`define PCR_CH0_MODE_LO       2
`define PCR_CH0_NOV_HI        1
`define PCR_CH0_NOV_LO        0

// buzzer prescale divide ratios, as log2 of the divisor
`define PCR_BUZ_DIV_LOG2_BASE 3'h3

// non-overlap clock counts for selects 00..11
`define PCR_NOV_CLK_0         3'h0
`define PCR_NOV_CLK_1         3'h1
`define PCR_NOV_CLK_2         3'h2
`define PCR_NOV_CLK_3         3'h4

`endif

// ===== dv/pcr_regs_checker.sv
/*
 pcr_regs_checker.sv: timing checks on the control register bank.
 assumes: bound into pcr_regs, ports matched by name.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // controls
    input wire logic [1:0] buzzer_prescale_select,
    input wire logic [2:0] buzzer_div_log2,
    input wire logic       buzzer_clk_en,
    input wire logic [7:0] pwm_ch0_period,
    input wire logic [1:0] ch0_nonoverlap_select,
    input wire logic [2:0] ch0_nonoverlap_clks,
    // ports
    input wire logic [7:0] port_a_pin_in,
    input wire logic [7:0] port_a_input_enable,
    input wire logic [7:0] port_a_din,
    input wire logic [5:0] port_b_pin_in,
    input wire logic [5:0] port_b_wakeup_enable,
    input wire logic       wakeup_req,
    input wire logic       reserved_write_seen
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // slowest divide is 64, so a tick never waits longer
    sequence s_next_tick;
        ##[1:64] buzzer_clk_en;
    endsequence
    a_tick_follows: assert property (buzzer_clk_en |-> s_next_tick)
        else $error("buzzer tick missing");
    a_psc_write: assert property (reg_wr && reg_addr == 8'h0e |=>
        buzzer_prescale_select == $past(reg_wdata[7:6]))
        else $error("prescale select not written");
    a_psc_decode: assert property (!$past(sys_rst) |->
        buzzer_div_log2 == 3'h3 + {1'b0, $past(buzzer_prescale_select)})
        else $error("divide ratio wrong");
    a_nov_decode: assert property (!$past(sys_rst) |->
        ch0_nonoverlap_clks == ($past(ch0_nonoverlap_select) == 2'h3 ?
        3'h4 : {1'b0, $past(ch0_nonoverlap_select)}))
        else $error("non-overlap count wrong");
    a_period_write: assert property (reg_wr && reg_addr == 8'h10 |=>
        pwm_ch0_period == $past(reg_wdata))
        else $error("period not written");
    a_din_gate: assert property (!$past(sys_rst) |->
        port_a_din == ($past(port_a_pin_in) & $past(port_a_input_enable)))
        else $error("input gating wrong");
    a_wake_level: assert property (!$past(sys_rst) |->
        wakeup_req == |($past(port_b_wakeup_enable) & ~$past(port_b_pin_in)))
        else $error("wake request wrong");
    a_rsv_set: assert property (reg_wr && reg_addr == 8'h0f |=>
        reserved_write_seen)
        else $error("reserved write not flagged");
    a_rsv_sticky: assert property (reserved_write_seen |=>
        reserved_write_seen)
        else $error("reserved flag dropped");
    a_rdata_zero: assert property (reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero");
endmodule
bind pcr_regs pcr_regs_checker u_pcr_regs_checker (.*);
`default_nettype wire

// ===== dv/testbench.sv
/*
 testbench.sv: random and corner writes to the control register bank.
 assumes: pcr_regs with its checker bound in; 250 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, a;
    logic [7:0] port_a_pin_in = 8'h00, port_d_pin_in = 8'h00;
    logic [5:0] port_b_pin_in = 6'h00;
    logic [7:0] reg_rdata, pwm_ch0_period, pwm_ch1_period, port_a_din;
    logic [7:0] port_a_input_enable, port_d_input_enable, port_d_din;
    logic [5:0] buzzer_period_value, port_b_input_enable, port_b_din;
    logic [5:0] port_b_wakeup_enable;
    logic [2:0] buzzer_div_log2, ch0_nonoverlap_clks, ch1_nonoverlap_clks;
    logic [1:0] buzzer_prescale_select, ch0_differential_mode;
    logic [1:0] ch1_differential_mode, ch0_nonoverlap_select;
    logic [1:0] ch1_nonoverlap_select;
    logic buzzer_clk_en, wakeup_req, reserved_write_seen, rs = 1'b0;
    // shadow copies start at the reset values
    logic [7:0] bz = 8'h00, p0 = 8'hff, p1 = 8'hff, pa = 8'hff, pd = 8'hff;
    logic [7:0] ctl = 8'h00;
    logic [5:0] pb = 6'h3f, wk = 6'h00;
    int errors = 0, tests_run = 0, cyc = 0, n, seed;
    pcr_regs u_pcr_regs (.*);
    always #2 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    function logic [2:0] nov(input logic [1:0] s);
        return (s == 2'h3) ? 3'h4 : {1'b0, s};
    endfunction
    task results;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        port_a_pin_in <= 8'($urandom);
        port_b_pin_in <= 6'($urandom);
        port_d_pin_in <= 8'($urandom);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        case (ad)
            8'h0e: bz = d;
            8'h0f: rs = 1'b1;
            8'h10: p0 = d;
            8'h11: p1 = d;
            8'h12: pa = d;
            8'h13: pb = d[5:0];
            8'h14: pd = d;
            8'h15: wk = d[5:0];
            8'h16: ctl = d;
            default: ;
        endcase
    endtask
    task rd(input logic [7:0] ad);
        @(posedge clk_sys);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK("rdata", 8'h00, reg_rdata)
    endtask
    task chk;
        @(posedge clk_sys);
        #1;
        `CHK("psc", bz[7:6], buzzer_prescale_select)
        `CHK("div", 3'h3 + {1'b0, bz[7:6]}, buzzer_div_log2)
        `CHK("buz prd", bz[5:0], buzzer_period_value)
        `CHK("prd0", p0, pwm_ch0_period)
        `CHK("prd1", p1, pwm_ch1_period)
        `CHK("pa en", pa, port_a_input_enable)
        `CHK("pb en", pb, port_b_input_enable)
        `CHK("pd en", pd, port_d_input_enable)
        `CHK("pa din", port_a_pin_in & pa, port_a_din)
        `CHK("pb din", port_b_pin_in & pb, port_b_din)
        `CHK("pd din", port_d_pin_in & pd, port_d_din)
        `CHK("wk en", wk, port_b_wakeup_enable)
        `CHK("wk req", |(wk & ~port_b_pin_in), wakeup_req)
        `CHK("m1", ctl[7:6], ch1_differential_mode)
        `CHK("n1", nov(ctl[5:4]), ch1_nonoverlap_clks)
        `CHK("m0", ctl[3:2], ch0_differential_mode)
        `CHK("n0", nov(ctl[1:0]), ch0_nonoverlap_clks)
        `CHK("rsv", rs, reserved_write_seen)
    endtask
    // counts cycles up to and including the next buzzer tick
    task tick(output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            #1;
            c++;
        end while (buzzer_clk_en !== 1'b1 && c < 200);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(73273);
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk;
        wr(8'h16, 8'h5a);
        chk;
        wr(8'h13, 8'hff);
        chk;
        wr(8'h0f, 8'h55);
        chk;
        for (int s = 0; s < 4; s++) begin
            wr(8'h0e, {s[1:0], 6'h15});
            repeat (2) tick(n);
            tick(n);
            `CHK("tick gap", 8 << s, n)
        end
        repeat (300) begin
            a = 8'h0c + 8'($urandom % 12);
            if (a == 8'h0f)
                a = 8'h10;
            if ($urandom % 4 == 0) begin
                rd(a);
            end else begin
                wr(a, 8'($urandom));
                chk;
            end
        end
        results;
    end
endmodule
`default_nettype wire
